// >>> rtl/tcc_ctrl.sv
/*
  Configuration and local calibration control for a networked pressure
  transmitter: node address capture, option decode, button calibration.
  Assumes all inputs are synchronous to sys_clk_in and that the first
  debounced switch values stand for the power-up state.
*/
`timescale 1ns/10ps
`default_nettype none
module tcc_ctrl
  import tcc_pkg::*;
#(
  parameter int unsigned TICK_DIV   = TICK_CYC,
  parameter int unsigned SETTLE_T   = ADDR_SETTLE_MS,
  parameter int unsigned HOLD_T     = CAL_HOLD_MS,
  parameter int unsigned DELAY_T    = CAL_DELAY_MS,
  parameter int unsigned WINDOW_T   = SPAN_WIN_MS,
  parameter int unsigned MSG_T      = MSG_SHOW_MS,
  parameter int unsigned LED_PER_T  = LED_PERIOD_MS,
  parameter int unsigned LED_ON_T   = LED_ON_MS,
  parameter int unsigned DEB_T      = DEBOUNCE_MS
) (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] addr_sw_in,
  input  wire logic [7:0] opt_sw_in,
  input  wire logic       zero_btn_in,
  input  wire logic       span_btn_in,
  input  wire logic [1:0] sec_level_in,
  input  wire logic       net_zero_in,
  input  wire logic       net_span_in,
  output tcc_node_t       node_out,
  output tcc_unit_t       unit_out,
  output logic            factory_reset_out,
  output tcc_cal_t        cal_out,
  output tcc_disp_t       disp_out,
  output logic            red_led_out
);

  // ************************************************************
  // Free-running tick and debounce
  // ************************************************************
  logic [31:0] div_ff;
  logic        tick_ff;
  logic [7:0]  addr_db;
  logic [7:0]  opt_db;
  logic [1:0]  btn_db;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else if (div_ff == 32'(TICK_DIV - 1)) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  tcc_debounce #(.W(18), .TICKS(DEB_T)) u_deb (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .tick_in    (tick_ff),
    .raw_in     ({addr_sw_in, opt_sw_in, zero_btn_in, span_btn_in}),
    .clean_out  ({addr_db, opt_db, btn_db})
  );

  // ************************************************************
  // Power-up capture and continuous unit decode
  // ************************************************************
  logic [15:0] boot_cnt_ff;
  logic        boot_done_ff;
  logic        boot_evt_ff;
  logic        addr_ok;

  // Valid address is 1..127; bit 7 set means out of range.
  assign addr_ok = (addr_db[7] == 1'b0) && (addr_db[6:0] >= ADDR_MIN)
                   && (addr_db[6:0] <= ADDR_MAX);

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_cnt_ff  <= 16'h0;
      boot_done_ff <= 1'b0;
      boot_evt_ff  <= 1'b0;
    end else begin
      boot_evt_ff <= 1'b0;
      if (!boot_done_ff && tick_ff) begin
        if (boot_cnt_ff == 16'(DEB_T + 2)) begin
          boot_done_ff <= 1'b1;
          boot_evt_ff  <= 1'b1;
        end else begin
          boot_cnt_ff <= boot_cnt_ff + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      factory_reset_out <= 1'b0;
    end else begin
      factory_reset_out <= boot_evt_ff && opt_db[OPT_FACT_BIT];
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unit_out <= TCC_UNIT_INWC;
    end else begin
      unit_out <= tcc_unit_t'(opt_db[OPT_UNIT_LSB +: 2]);
    end
  end

  // ************************************************************
  // Node address tracking
  // ************************************************************
  logic [7:0]  last_sw_ff;
  logic [31:0] settle_ff;
  logic        pend_ff;

  // Factory setting 127 is a legal address and is adopted at power-up.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_sw_ff <= ADDR_FACTORY;
      settle_ff  <= 32'h0;
      pend_ff    <= 1'b0;
      node_out   <= '0;
    end else begin
      node_out.baud_restart <= 1'b0;
      if (boot_evt_ff) begin
        last_sw_ff            <= addr_db;
        node_out.addr         <= addr_db[6:0];
        node_out.valid        <= addr_ok;
        node_out.respond      <= addr_ok;
        node_out.baud_restart <= 1'b1;
      end else if (boot_done_ff && addr_db != last_sw_ff) begin
        last_sw_ff       <= addr_db;
        settle_ff        <= 32'h0;
        pend_ff          <= 1'b1;
        node_out.respond <= 1'b0;
      end else if (pend_ff && tick_ff) begin
        if (settle_ff == 32'(SETTLE_T - 1)) begin
          pend_ff               <= 1'b0;
          node_out.addr         <= addr_db[6:0];
          node_out.valid        <= addr_ok;
          node_out.respond      <= addr_ok;
          node_out.baud_restart <= 1'b1;
        end else begin
          settle_ff <= settle_ff + 32'h1;
        end
      end
    end
  end

  // ************************************************************
  // Invalid address blink
  // ************************************************************
  logic [15:0] led_cnt_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      led_cnt_ff  <= 16'h0;
      red_led_out <= 1'b0;
    end else begin
      if (tick_ff) begin
        led_cnt_ff <= (led_cnt_ff == 16'(LED_PER_T - 1)) ? 16'h0 : led_cnt_ff + 16'h1;
      end
      red_led_out <= boot_done_ff && !addr_ok
                     && (led_cnt_ff < 16'(LED_ON_T));
    end
  end

  // ************************************************************
  // Calibration sequencer
  // ************************************************************
  typedef enum logic [4:0] {
    CS_IDLE  = 5'b00001,
    CS_HOLDZ = 5'b00010,
    CS_HOLDS = 5'b00100,
    CS_WAIT  = 5'b01000,
    CS_REL   = 5'b10000
  } tcc_cst_t;

  tcc_cst_t    cst_ff;
  logic [31:0] ccnt_ff;
  logic        is_span_ff;
  logic        zero_done_ff;
  logic [31:0] win_ff;
  logic        zero_ok;
  logic        span_ok;
  logic        cal_zero_evt;
  logic        cal_span_evt;
  logic        fail_evt;

  assign zero_ok = (sec_level_in != 2'h3);
  assign span_ok = (sec_level_in == 2'h0) && zero_done_ff;
  assign cal_zero_evt = (cst_ff == CS_WAIT) && tick_ff && !is_span_ff
                        && ccnt_ff == 32'(DELAY_T - 1);
  assign cal_span_evt = (cst_ff == CS_WAIT) && tick_ff && is_span_ff
                        && ccnt_ff == 32'(DELAY_T - 1);
  assign fail_evt = (cst_ff == CS_IDLE) && btn_db[0] && !btn_db[1]
                    && (sec_level_in == 2'h0) && !zero_done_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cst_ff     <= CS_IDLE;
      ccnt_ff    <= 32'h0;
      is_span_ff <= 1'b0;
    end else begin
      case (cst_ff)
        CS_IDLE: begin
          ccnt_ff <= 32'h0;
          if (btn_db[1] && !btn_db[0] && zero_ok) begin
            cst_ff     <= CS_HOLDZ;
            is_span_ff <= 1'b0;
          end else if (btn_db[0] && !btn_db[1] && span_ok) begin
            cst_ff     <= CS_HOLDS;
            is_span_ff <= 1'b1;
          end else if (fail_evt) begin
            cst_ff <= CS_REL;
          end
        end
        CS_HOLDZ, CS_HOLDS: begin
          if (!btn_db[is_span_ff ? 0 : 1]) begin
            cst_ff <= CS_IDLE;
          end else if (tick_ff) begin
            if (ccnt_ff == 32'(HOLD_T - 1)) begin
              cst_ff  <= CS_REL;
              ccnt_ff <= 32'h0;
            end else begin
              ccnt_ff <= ccnt_ff + 32'h1;
            end
          end
        end
        CS_REL: begin
          ccnt_ff <= 32'h0;
          if (btn_db == 2'b00) begin
            // A refused span attempt must never reach the apply delay.
            cst_ff <= (!fail_ff && (zero_done_ff || !is_span_ff)) ? CS_WAIT : CS_IDLE;
          end
        end
        CS_WAIT: begin
          if (tick_ff) begin
            if (ccnt_ff == 32'(DELAY_T - 1)) begin
              cst_ff <= CS_IDLE;
            end else begin
              ccnt_ff <= ccnt_ff + 32'h1;
            end
          end
        end
        default: cst_ff <= CS_IDLE;
      endcase
    end
  end

  // Failed span attempts enter CS_REL with is_span_ff kept from the last attempt and no hold, so
  // a separate flag keeps them from applying a zero.
  logic fail_ff;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fail_ff <= 1'b0;
    end else if (fail_evt) begin
      fail_ff <= 1'b1;
    end else if (cst_ff == CS_IDLE) begin
      fail_ff <= 1'b0;
    end
  end

  // Network requests pass through one register stage, whatever the security level.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cal_out <= '0;
    end else begin
      cal_out.zero_apply <= net_zero_in || (cal_zero_evt && !fail_ff);
      cal_out.span_apply <= net_span_in || cal_span_evt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_done_ff <= 1'b0;
      win_ff       <= 32'h0;
    end else if (cal_zero_evt && !fail_ff) begin
      zero_done_ff <= 1'b1;
      win_ff       <= 32'h0;
    end else if (zero_done_ff && tick_ff) begin
      if (win_ff == 32'(WINDOW_T - 1) || cal_span_evt) begin
        zero_done_ff <= 1'b0;
      end else begin
        win_ff <= win_ff + 32'h1;
      end
    end
  end

  // ************************************************************
  // Display selection
  // ************************************************************
  logic [31:0] msg_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      disp_out <= TCC_DISP_HOME;
      msg_ff   <= 32'h0;
    end else if (boot_evt_ff) begin
      disp_out <= addr_ok ? TCC_DISP_ADDR : TCC_DISP_ADDR_ERR;
      msg_ff   <= 32'h0;
    end else if (cal_zero_evt && !fail_ff) begin
      disp_out <= TCC_DISP_ZERO_OK;
      msg_ff   <= 32'h0;
    end else if (cal_span_evt) begin
      disp_out <= TCC_DISP_SPAN_OK;
      msg_ff   <= 32'h0;
    end else if (fail_evt) begin
      disp_out <= TCC_DISP_CAL_FAIL;
      msg_ff   <= 32'h0;
    end else if (disp_out != TCC_DISP_HOME && tick_ff) begin
      if (msg_ff == 32'(MSG_T - 1)) begin
        disp_out <= TCC_DISP_HOME;
      end else begin
        msg_ff <= msg_ff + 32'h1;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_addr_range;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      node_out.valid |-> (node_out.addr != 7'h00);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("invalid address marked valid");

  property p_stop_answer;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (boot_done_ff && !boot_evt_ff && addr_db != last_sw_ff) |=> !node_out.respond;
  endproperty
  a_stop_answer: assert property (p_stop_answer) else $error("old address still answered");

  property p_baud;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      $changed(node_out.addr) |-> node_out.baud_restart;
  endproperty
  a_baud: assert property (p_baud) else $error("baud detect not restarted");

  property p_led;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      red_led_out |-> $past(boot_done_ff) && !$past(addr_ok);
  endproperty
  a_led: assert property (p_led) else $error("blink with valid address");

  property p_unit;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      ##1 (unit_out == $past(opt_db[1:0]));
  endproperty
  a_unit: assert property (p_unit) else $error("unit decode wrong");

  property p_span_gate;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (cst_ff == CS_IDLE && !zero_done_ff) |=> (cst_ff != CS_HOLDS);
  endproperty
  a_span_gate: assert property (p_span_gate) else $error("span hold without zero");

  property p_sec3;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (cst_ff == CS_IDLE && sec_level_in == 2'h3) |=> (cst_ff == CS_IDLE || cst_ff == CS_REL);
  endproperty
  a_sec3: assert property (p_sec3) else $error("level 3 button accepted");

  sequence s_zero_fire;
    cal_zero_evt && !fail_ff;
  endsequence
  property p_zero_msg;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      s_zero_fire |=> (disp_out == TCC_DISP_ZERO_OK) && cal_out.zero_apply && zero_done_ff;
  endproperty
  a_zero_msg: assert property (p_zero_msg) else $error("zero completion missing");

  property p_early_rel;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      (cst_ff == CS_HOLDZ && !btn_db[1]) |=> (cst_ff == CS_IDLE);
  endproperty
  a_early_rel: assert property (p_early_rel) else $error("early release not cancelled");

endmodule : tcc_ctrl
`default_nettype wire

// >>> rtl/tcc_pkg.sv
/*
  Package for the transmitter configuration and calibration control block.
  Holds timing figures, switch field positions, display codes and carriers.
  Assumes a 100 MHz system clock.
*/
package tcc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_HZ         = 1000;
  localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned ADDR_SETTLE_S   = 15;
  localparam int unsigned ADDR_SETTLE_MS  = ADDR_SETTLE_S * 1000;
  localparam int unsigned CAL_HOLD_S      = 3;
  localparam int unsigned CAL_HOLD_MS     = CAL_HOLD_S * 1000;
  localparam int unsigned CAL_DELAY_S     = 5;
  localparam int unsigned CAL_DELAY_MS    = CAL_DELAY_S * 1000;
  localparam int unsigned SPAN_WIN_MIN    = 5;
  localparam int unsigned SPAN_WIN_MS     = SPAN_WIN_MIN * 60 * 1000;
  localparam int unsigned MSG_SHOW_MS     = 2000;
  localparam int unsigned LED_PERIOD_MS   = 2000;
  localparam int unsigned LED_ON_MS       = 200;

  // ************************************************************
  // Address and option switches
  // ************************************************************
  localparam logic [6:0] ADDR_MIN        = 7'h01;
  localparam logic [6:0] ADDR_MAX        = 7'h7f;
  localparam logic [7:0] ADDR_FACTORY    = 8'h7f;
  localparam int unsigned OPT_UNIT_LSB   = 0;
  localparam int unsigned OPT_FACT_BIT   = 4;

  typedef enum logic [1:0] {
    TCC_UNIT_INWC = 2'h0,
    TCC_UNIT_PA   = 2'h1,
    TCC_UNIT_MMWC = 2'h2,
    TCC_UNIT_KPA  = 2'h3
  } tcc_unit_t;

  typedef enum logic [2:0] {
    TCC_DISP_HOME     = 3'h0,
    TCC_DISP_ADDR     = 3'h1,
    TCC_DISP_ADDR_ERR = 3'h2,
    TCC_DISP_ZERO_OK  = 3'h3,
    TCC_DISP_SPAN_OK  = 3'h4,
    TCC_DISP_CAL_FAIL = 3'h5
  } tcc_disp_t;

  // Calibration requests handed to the measurement side.
  typedef struct packed {
    logic zero_apply;
    logic span_apply;
  } tcc_cal_t;

  // Node address state handed to the network engine.
  typedef struct packed {
    logic [6:0] addr;
    logic       valid;
    logic       respond;
    logic       baud_restart;
  } tcc_node_t;

endpackage : tcc_pkg

// >>> rtl/tcc_debounce.sv
/*
  Debouncer: an input is passed on once it has held one value for a set
  number of ticks. Assumes the input is synchronous to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
module tcc_debounce
  import tcc_pkg::*;
#(
  parameter int unsigned W     = 1,
  parameter int unsigned TICKS = DEBOUNCE_MS
) (
  input  wire logic         sys_clk_in,
  input  wire logic         nrst_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] clean_out
);
  logic [W-1:0] cand_ff;
  logic [15:0]  cnt_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cand_ff   <= '0;
      cnt_ff    <= 16'h0000;
      clean_out <= '0;
    end else if (raw_in != cand_ff) begin
      cand_ff <= raw_in;
      cnt_ff  <= 16'h0000;
    end else if (tick_in) begin
      if (cnt_ff == 16'(TICKS)) begin
        clean_out <= cand_ff;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule : tcc_debounce
`default_nettype wire

// >>> test/tcc_installer.sv
/*
  Installer model: sets the address and option switch banks and presses the
  zero and span buttons for a chosen number of clock cycles.
  Assumes the testbench calls its tasks and that sys_clk_in is free running.
*/
`timescale 1ns/10ps
`default_nettype none
module tcc_installer
  import tcc_pkg::*;
(
  input  wire logic       sys_clk_in,
  output logic      [7:0] addr_sw_out,
  output logic      [7:0] opt_sw_out,
  output logic            zero_btn_out,
  output logic            span_btn_out
);
  // ************************************************************
  // Switch and button drive
  // ************************************************************
  initial begin
    addr_sw_out  = ADDR_FACTORY;
    opt_sw_out   = 8'h00;
    zero_btn_out = 1'b0;
    span_btn_out = 1'b0;
  end

  task automatic set_sw(input logic [7:0] addr, input logic [7:0] opt);
    @(posedge sys_clk_in);
    addr_sw_out <= addr;
    opt_sw_out  <= opt;
  endtask : set_sw

  // One button at a time; the other stays released.
  task automatic press(input logic zero, input int cycles);
    @(posedge sys_clk_in);
    if (zero) begin
      zero_btn_out <= 1'b1;
    end else begin
      span_btn_out <= 1'b1;
    end
    repeat (cycles) @(posedge sys_clk_in);
    zero_btn_out <= 1'b0;
    span_btn_out <= 1'b0;
  endtask : press
endmodule : tcc_installer
`default_nettype wire

// >>> test/tcc_ctrl_tb_top.sv
/*
  Self-checking testbench for the configuration and calibration control.
  Assumes a tick on every cycle, shortened settle, hold, delay and span
  window; debounce, message and LED timing keep their package values.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((e) !== (a)) begin err_total++; \
  $display("FAIL %s expected %0h seen %0h", n, e, a); end end
module tcc_ctrl_tb_top;
  import tcc_pkg::*;
  localparam int SET = 200;
  localparam int HLD = 40;
  localparam int DLY = 40;
  localparam int WIN = 1000;
  logic       sys_clk;
  logic       nrst;
  logic [7:0] addr_sw;
  logic [7:0] opt_sw;
  logic       zero_btn;
  logic       span_btn;
  logic [1:0] sec_level;
  logic       net_zero;
  logic       net_span;
  tcc_node_t  node;
  tcc_unit_t  unit;
  logic       fact;
  tcc_cal_t   cal;
  tcc_disp_t  disp;
  logic       red_led;
  tcc_disp_t  zd;
  tcc_disp_t  sd;
  logic       fail_seen = 1'b0;
  int         err_total, cmp_count, zc, sc, fc, bc, ledc;

  tcc_installer installer (.sys_clk_in(sys_clk), .addr_sw_out(addr_sw), .opt_sw_out(opt_sw),
    .zero_btn_out(zero_btn), .span_btn_out(span_btn));

  tcc_ctrl #(.TICK_DIV(1), .SETTLE_T(SET), .HOLD_T(HLD), .DELAY_T(DLY),
    .WINDOW_T(WIN)) DUT (.sys_clk_in(sys_clk), .nrst_in(nrst),
    .addr_sw_in(addr_sw), .opt_sw_in(opt_sw), .zero_btn_in(zero_btn), .span_btn_in(span_btn),
    .sec_level_in(sec_level), .net_zero_in(net_zero), .net_span_in(net_span),
    .node_out(node), .unit_out(unit), .factory_reset_out(fact), .cal_out(cal),
    .disp_out(disp), .red_led_out(red_led));

  // ************************************************************
  // Clock, pulse counters and helpers
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulses are counted so that a missing or doubled pulse shows as a count.
  always @(posedge sys_clk) begin
    if (cal.zero_apply === 1'b1) begin
      zc++;
      zd = disp;
    end
    if (cal.span_apply === 1'b1) begin
      sc++;
      sd = disp;
    end
    if (fact === 1'b1) fc++;
    if (node.baud_restart === 1'b1) bc++;
    if (red_led === 1'b1) ledc++;
    if (disp === TCC_DISP_CAL_FAIL) fail_seen = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic cal_try(input logic z, input int hold, input logic [1:0] lvl,
                         input int ez, input int es);
    int z0;
    int s0;
    @(posedge sys_clk);
    sec_level <= lvl;
    z0 = zc;
    s0 = sc;
    installer.press(z, hold);
    cyc(DEBOUNCE_MS + DLY - 10);
    `CHK("early apply", 0, zc - z0 + sc - s0)
    cyc(40);
    `CHK("zero apply", ez, zc - z0)
    `CHK("span apply", es, sc - s0)
  endtask : cal_try

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot(input logic [7:0] a, input logic [7:0] o, input int ef,
                        input tcc_disp_t ed);
    int f0;
    int b0;
    int i;
    f0 = fc;
    b0 = bc;
    @(posedge sys_clk);
    nrst <= 1'b0;
    installer.set_sw(a, o);
    cyc(20);
    @(posedge sys_clk);
    nrst <= 1'b1;
    for (i = 0; i < 100 && bc == b0; i++) @(posedge sys_clk);
    cyc(3);
    `CHK("boot restart", 1, bc - b0)
    `CHK("factory reset", ef, fc - f0)
    `CHK("boot display", ed, disp)
    `CHK("addr valid", (a >= 8'h01 && a <= 8'h7f), node.valid)
    if (ed == TCC_DISP_ADDR) `CHK("boot addr", a[6:0], node.addr)
    $display("boot test done");
  endtask : t_boot

  task automatic t_units();
    tcc_unit_t ue[4] = '{TCC_UNIT_INWC, TCC_UNIT_PA, TCC_UNIT_MMWC, TCC_UNIT_KPA};
    for (int i = 0; i < 4; i++) begin
      installer.set_sw(8'h7f, {6'h00, i[1:0]});
      cyc(DEBOUNCE_MS + 10);
      `CHK("unit", ue[i], unit)
    end
    $display("unit test done");
  endtask : t_units

  task automatic t_cal();
    fail_seen = 1'b0;
    cal_try(1'b0, HLD + 20, 2'h0, 0, 0);
    `CHK("fail message", 1'b1, fail_seen)
    cal_try(1'b1, HLD + 20, 2'h0, 1, 0);
    `CHK("zero message", TCC_DISP_ZERO_OK, zd)
    cal_try(1'b0, HLD + 20, 2'h0, 0, 1);
    `CHK("span message", TCC_DISP_SPAN_OK, sd)
    cal_try(1'b1, HLD / 2, 2'h0, 0, 0);
    cal_try(1'b1, HLD + 20, 2'h0, 1, 0);
    cyc(WIN);
    cal_try(1'b0, HLD + 20, 2'h0, 0, 0);
    $display("calibration test done");
  endtask : t_cal

  task automatic t_sec();
    int z0;
    int s0;
    cal_try(1'b1, HLD + 20, 2'h3, 0, 0);
    cal_try(1'b1, HLD + 20, 2'h1, 1, 0);
    cal_try(1'b0, HLD + 20, 2'h1, 0, 0);
    cal_try(1'b1, HLD + 20, 2'h2, 1, 0);
    cal_try(1'b0, HLD + 20, 2'h2, 0, 0);
    z0 = zc;
    s0 = sc;
    @(posedge sys_clk);
    sec_level <= 2'h3;
    net_zero  <= 1'b1;
    net_span  <= 1'b1;
    @(posedge sys_clk);
    net_zero  <= 1'b0;
    net_span  <= 1'b0;
    cyc(3);
    `CHK("net zero", 1, zc - z0)
    `CHK("net span", 1, sc - s0)
    $display("security test done");
  endtask : t_sec

  task automatic t_addr();
    int b0;
    int l0;
    int i;
    b0 = bc;
    l0 = ledc;
    installer.set_sw(8'h05, 8'h00);
    cyc(DEBOUNCE_MS + 5);
    `CHK("respond after change", 1'b0, node.respond)
    installer.set_sw(8'h01, 8'h00);
    cyc(DEBOUNCE_MS + SET / 2);
    `CHK("respond while settling", 1'b0, node.respond)
    for (i = 0; i < 2 * SET && node.respond !== 1'b1; i++) @(posedge sys_clk);
    cyc(1);
    `CHK("new addr", 7'h01, node.addr)
    `CHK("respond new addr", 1'b1, node.respond)
    `CHK("addr restart", 1, bc - b0)
    `CHK("led while valid", 0, ledc - l0)
    installer.set_sw(8'h80, 8'h00);
    cyc(DEBOUNCE_MS + SET + 20);
    `CHK("addr 128 valid", 1'b0, node.valid)
    l0 = ledc;
    cyc(2 * LED_PERIOD_MS);
    `CHK("led on cycles", 2 * LED_ON_MS, ledc - l0)
    $display("address test done");
  endtask : t_addr

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    nrst      = 1'b0;
    sec_level = 2'h0;
    net_zero  = 1'b0;
    net_span  = 1'b0;
    t_boot(8'h7f, 8'h11, 1, TCC_DISP_ADDR);
    t_units();
    t_cal();
    t_sec();
    t_addr();
    t_boot(8'h00, 8'h00, 0, TCC_DISP_ADDR_ERR);
    results();
  end

  initial begin
    #400000;
    err_total++;
    $display("FAIL watchdog expected finish seen hang");
    results();
  end
endmodule : tcc_ctrl_tb_top
`default_nettype wire
